// file: rtl/vectored_interrupt_group_regs.sv
// One eight-input vectored interrupt controller group with its register set
// Function
// - Status bit seven mirrors the group interrupt output, also in polled mode.
// - Status bit six shows chain enable input; first group always enabled.
// - Status bit five high when rotating priority selected in mode bit zero.
// - Status bit four high when polled mode selected in mode bit two.
// - Status bit three follows master arm; disarmed group raises no interrupt.
// - Control port read returns status; control port write loads command.
// - Command register holds last command; opcode acts or preselects data port.
// - Low five mode bits load together; upper three by separate commands.
// - Mode register unreadable except via status; clears on any reset.
// - Request bit sets on inactive-to-active edge meeting minimum pulse width.
// - Request bits clear on reset and acknowledge; commands set or clear them.
// - Readback register chosen by mode bits five and six, then data read.
// - Acknowledge picks top pending unmasked request, clears it, sets service.
// - Fixed priority: only strictly higher requests pass a set service bit.
// - Rotating priority: any set service bit blocks every request.
// - Fence rises with newer higher service bit, falls back when cleared.
// - Mask one blocks; masked latched request fires once unmasked; resets set mask.
// - Mask loads, sets, clears all bits or single bits by command.
// - Auto-clear bit clears service bit within acknowledge; else command clears.
// - Auto-clear register loads by preselect command then data port write.
// - All-zero command performs a software reset of the group.
// - Polled mode forces the group interrupt output inactive.
`timescale 1ns/1ns
module vectored_interrupt_group_regs
	import vig_pkg::*;
#(
	parameter bit FIRST_GROUP = 1'b1,
	parameter int PULSE_CYC = vig_pkg::MIN_PULSE_CYC
)
(
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic reset_i,
	// Host parallel port
	input wire vig_pkg::host_access_t host_i,
	input wire logic acknowledge_strobe_i,
	output logic [7:0] bus_data_o,
	output logic bus_data_oe_o,
	// Request and chain pins
	input wire logic [7:0] irq_pin_i,
	input wire logic chain_enable_in_i,
	// Group interrupt
	output logic group_irq_out_o
);
	import vig_pkg::*;

	// Counter must hold the pulse width
	if (PULSE_CYC < 1 || PULSE_CYC > 15)
	begin : g_chk
		$error("PULSE_CYC out of range");
	end

	// Single bit or all bits, as commands address them
	function automatic logic [7:0] bit_sel(input logic all, input logic [2:0] idx);
		bit_sel = all ? 8'hff : (8'h01 << idx);
	endfunction

	// First set bit of vec, searching upward from start with wrap
	function automatic logic [2:0] pick(input logic [7:0] vec, input logic [2:0] start);
		logic [2:0] k;
		pick = start;
		for (int i = 7; i >= 0; i--)
		begin
			k = start + 3'(i);
			if (vec[k])
				pick = k;
		end
	endfunction

	// Registers
	logic [7:0] mode_r;
	logic [7:0] cmd_r;
	logic [7:0] req_r;
	logic [7:0] svc_r;
	logic [7:0] mask_r;
	logic [7:0] aclr_r;
	logic [7:0] vec_mem_r [8];
	logic [2:0] vec_idx_r;
	logic [2:0] last_r;
	logic irq_r;
	logic [7:0] dout_r;
	logic oe_r;
	port_target_t tgt_r;
	// Synchronisers and pulse qualifiers
	logic [7:0] s1_r, s2_r, s3_r, lvl_r;
	logic c1_r, c2_r, c3_r, chain_r;
	logic [3:0] pw_cnt_r [8];
	logic [7:0] edge_set;

	// Bus decode
	wire cmd_wr = host_i.sel && host_i.ctrl && host_i.wr;
	wire dat_wr = host_i.sel && !host_i.ctrl && host_i.wr;
	wire stat_rd = host_i.sel && host_i.ctrl && host_i.rd;
	wire dat_rd = host_i.sel && !host_i.ctrl && host_i.rd;
	wire [2:0] op = host_i.data[CMD_OP_HI:CMD_OP_LO];
	wire [7:0] cmd_bits = bit_sel(host_i.data[CMD_ALL_POS], host_i.data[2:0]);
	wire cmd_set = host_i.data[CMD_SET_POS];
	wire soft_rst = cmd_wr && host_i.data == CMD_SOFT_RESET;
	wire op_mode_lo = cmd_wr && !soft_rst && op == OP_MODE_LO;
	wire op_mode_hi = cmd_wr && op == OP_MODE_HI;
	wire op_req = cmd_wr && op == OP_REQ;
	wire op_mask = cmd_wr && op == OP_MASK;
	wire op_svc = cmd_wr && op == OP_SVC;
	wire op_presel = cmd_wr && op == OP_PRESEL;
	wire op_vecsel = cmd_wr && op == OP_VECSEL;

	// Status mirror; low three bits are internal and read zero
	wire chain_ok = FIRST_GROUP ? 1'b1 : chain_r;
	wire [7:0] status = {irq_r, chain_ok, mode_r[MODE_ROTATE], mode_r[MODE_POLLED],
		mode_r[MODE_ARM], 3'h0};

	// Priority fence: fixed admits only indices below the lowest set service bit
	wire rotate = mode_r[MODE_ROTATE];
	wire [2:0] top_svc = pick(svc_r, 3'h0);
	wire [7:0] fence = (svc_r == 8'h00) ? 8'hff :
		rotate ? 8'h00 :
		~(8'hff << top_svc);
	wire [7:0] pending = req_r & ~mask_r & fence;
	wire [2:0] start = rotate ? last_r + 3'h1 : 3'h0;
	wire [2:0] win = pick(pending, start);
	wire irq_nxt = (pending != 8'h00) && mode_r[MODE_ARM] && !mode_r[MODE_POLLED]
		&& chain_ok;
	// Acknowledge only honoured while the group is actually requesting
	wire ack = acknowledge_strobe_i && irq_r && (pending != 8'h00);
	wire [7:0] win_bit = bit_sel(1'b0, win);
	wire svc_keep = !aclr_r[win];

	// Set and clear masks; a hardware set wins over any clear
	wire [7:0] req_clr = (ack ? win_bit : 8'h00) |
		((op_req && !cmd_set) ? cmd_bits : 8'h00);
	wire [7:0] req_set = edge_set | ((op_req && cmd_set) ? cmd_bits : 8'h00);
	wire [7:0] svc_clr = op_svc ? cmd_bits : 8'h00;
	wire [7:0] svc_set = (ack && svc_keep) ? win_bit : 8'h00;
	wire [7:0] req_nxt = (req_r & ~req_clr) | req_set;
	wire [7:0] svc_nxt = (svc_r & ~svc_clr) | svc_set;

	// Data port readback picked by mode bits six and five
	wire [1:0] rb_sel = mode_r[MODE_SEL_HI:MODE_SEL_LO];
	wire [7:0] rb_data = (rb_sel == RB_SERVICE) ? svc_r :
		(rb_sel == RB_MASK) ? mask_r :
		(rb_sel == RB_REQUEST) ? req_r : aclr_r;
	wire [2:0] vec_slot = mode_r[MODE_COMMON] ? 3'h0 : win;

	// Three-stage pin synchronisers; level moves when stages two and three agree
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			s1_r <= ZERO_RST;
			s2_r <= ZERO_RST;
			s3_r <= ZERO_RST;
			lvl_r <= ZERO_RST;
			c1_r <= 1'b0;
			c2_r <= 1'b0;
			c3_r <= 1'b0;
			chain_r <= 1'b0;
		end
		else
		begin
			s1_r <= irq_pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= (s2_r & ~(s2_r ^ s3_r)) | (lvl_r & (s2_r ^ s3_r));
			c1_r <= chain_enable_in_i;
			c2_r <= c1_r;
			c3_r <= c2_r;
			chain_r <= (c2_r == c3_r) ? c2_r : chain_r;
		end
	end

	// Pulse width qualifier: fires once per active period, low level rearms it
	for (genvar g = 0; g < N_REQ; g++)
	begin : g_pw
		assign edge_set[g] = lvl_r[g] && pw_cnt_r[g] == 4'(PULSE_CYC - 1);
		always_ff @(posedge clk_sys_i or posedge reset_i)
		begin
			if (reset_i)
				pw_cnt_r[g] <= 4'h0;
			else if (!lvl_r[g])
				pw_cnt_r[g] <= 4'h0;
			else if (pw_cnt_r[g] != 4'(PULSE_CYC))
				pw_cnt_r[g] <= pw_cnt_r[g] + 4'h1;
		end
	end

	// Command and mode registers
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			cmd_r <= ZERO_RST;
			mode_r <= MODE_RST;
		end
		else
		begin
			if (cmd_wr)
				cmd_r <= host_i.data;
			if (soft_rst)
				mode_r <= MODE_RST;
			else if (op_mode_lo)
				mode_r[MODE_LOW_W-1:0] <= cmd_r[MODE_LOW_W-1:0] ^ cmd_r[MODE_LOW_W-1:0]
					^ host_i.data[MODE_LOW_W-1:0];
			else if (op_mode_hi && !host_i.data[CMD_ALL_POS])
				mode_r[MODE_SEL_HI:MODE_SEL_LO] <= host_i.data[1:0];
			else if (op_mode_hi)
				mode_r[MODE_ARM] <= host_i.data[0];
		end
	end

	// Request, service, mask and auto-clear registers
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			req_r <= ZERO_RST;
			svc_r <= ZERO_RST;
			mask_r <= MASK_RST;
			aclr_r <= ZERO_RST;
			last_r <= 3'h7;
		end
		else if (soft_rst)
		begin
			req_r <= ZERO_RST;
			svc_r <= ZERO_RST;
			mask_r <= MASK_RST;
			last_r <= 3'h7;
		end
		else
		begin
			req_r <= req_nxt;
			svc_r <= svc_nxt;
			if (dat_wr && tgt_r == TGT_MASK)
				mask_r <= host_i.data;
			else if (op_mask)
				mask_r <= cmd_set ? (mask_r | cmd_bits) : (mask_r & ~cmd_bits);
			if (dat_wr && tgt_r == TGT_ACLR)
				aclr_r <= host_i.data;
			if (ack)
				last_r <= win;
		end
	end

	// Data port target; a vector slot takes exactly one byte per preselect
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			tgt_r <= TGT_NONE;
			vec_idx_r <= 3'h0;
		end
		else if (soft_rst)
			tgt_r <= TGT_NONE;
		else if (op_presel)
			tgt_r <= host_i.data[0] ? TGT_ACLR : TGT_MASK;
		else if (op_vecsel)
		begin
			tgt_r <= TGT_VEC;
			vec_idx_r <= host_i.data[2:0];
		end
		else if (dat_wr && tgt_r == TGT_VEC)
			tgt_r <= TGT_NONE;
	end

	// Vector memory survives a software reset
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			for (int i = 0; i < N_REQ; i++)
				vec_mem_r[i] <= ZERO_RST;
		end
		else if (dat_wr && tgt_r == TGT_VEC)
			vec_mem_r[vec_idx_r] <= host_i.data;
	end

	// Bus drive and interrupt; a read or acknowledge drives one cycle later
	always_ff @(posedge clk_sys_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			irq_r <= 1'b0;
			dout_r <= ZERO_RST;
			oe_r <= 1'b0;
		end
		else
		begin
			irq_r <= irq_nxt;
			oe_r <= stat_rd || dat_rd || ack;
			if (ack)
				dout_r <= vec_mem_r[vec_slot];
			else if (stat_rd)
				dout_r <= status;
			else if (dat_rd)
				dout_r <= rb_data;
		end
	end

	assign group_irq_out_o = irq_r;
	assign bus_data_o = dout_r;
	assign bus_data_oe_o = oe_r;

	// Checks
	AST_IRQ_MIRROR: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		stat_rd && !ack |=> (bus_data_o[ST_IRQ] == $past(irq_r)) && bus_data_oe_o)
		else $error("status bit seven does not mirror interrupt");
	AST_STATUS_MODE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		stat_rd && !ack |=> bus_data_o[ST_ROTATE] == $past(mode_r[MODE_ROTATE])
		&& bus_data_o[ST_POLLED] == $past(mode_r[MODE_POLLED])
		&& bus_data_o[ST_ARMED] == $past(mode_r[MODE_ARM]))
		else $error("status mode flags wrong");
	AST_CHAIN: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		stat_rd && !ack |=> bus_data_o[ST_CHAIN] == (FIRST_GROUP || $past(chain_r)))
		else $error("chain enable flag wrong");
	AST_SOFT_RESET: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		soft_rst |=> mode_r == MODE_RST && mask_r == MASK_RST && req_r == ZERO_RST
		&& svc_r == ZERO_RST)
		else $error("software reset incomplete");
	AST_POLLED_QUIET: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		mode_r[MODE_POLLED] |=> !group_irq_out_o)
		else $error("interrupt while polled");
	AST_DISARMED: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!mode_r[MODE_ARM] |=> !group_irq_out_o)
		else $error("interrupt while disarmed");
	AST_ROTATE_FENCE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		rotate && svc_r != 8'h00 |=> !group_irq_out_o)
		else $error("rotating fence breached");
	AST_ACK_SERVICE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		ack && !soft_rst && !op_svc |=> svc_r[$past(win)] == !$past(aclr_r[win])
		&& bus_data_oe_o)
		else $error("acknowledge did not update service");
	AST_FIXED_FENCE: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		!rotate && svc_r != 8'h00 && (req_r & ~mask_r & ~(8'hff << top_svc)) == 8'h00
		|=> !group_irq_out_o)
		else $error("fixed fence breached");
	AST_EDGE_SET: assert property (@(posedge clk_sys_i) disable iff (reset_i)
		edge_set != 8'h00 && !soft_rst |=> (req_r & $past(edge_set)) == $past(edge_set))
		else $error("qualified edge lost");
endmodule

// file: rtl/vig_pkg.sv
// Shared constants and types for one vectored interrupt controller group
package vig_pkg;
	// Widths
	localparam int N_REQ = 8;
	localparam int IDX_W = 3;
	// Command opcode field and opcodes
	localparam int CMD_OP_HI = 7;
	localparam int CMD_OP_LO = 5;
	localparam logic [2:0] OP_MODE_LO = 3'h0;
	localparam logic [2:0] OP_MODE_HI = 3'h1;
	localparam logic [2:0] OP_REQ = 3'h2;
	localparam logic [2:0] OP_MASK = 3'h3;
	localparam logic [2:0] OP_SVC = 3'h4;
	localparam logic [2:0] OP_PRESEL = 3'h5;
	localparam logic [2:0] OP_VECSEL = 3'h6;
	localparam logic [7:0] CMD_SOFT_RESET = 8'h00;
	// Command field positions
	localparam int CMD_SET_POS = 4;
	localparam int CMD_ALL_POS = 3;
	localparam int CMD_CNT_HI = 4;
	localparam int CMD_CNT_LO = 3;
	// Mode bit positions
	localparam int MODE_ROTATE = 0;
	localparam int MODE_COMMON = 1;
	localparam int MODE_POLLED = 2;
	localparam int MODE_LOW_W = 5;
	localparam int MODE_SEL_LO = 5;
	localparam int MODE_SEL_HI = 6;
	localparam int MODE_ARM = 7;
	// Status bit positions
	localparam int ST_IRQ = 7;
	localparam int ST_CHAIN = 6;
	localparam int ST_ROTATE = 5;
	localparam int ST_POLLED = 4;
	localparam int ST_ARMED = 3;
	// Readback selection codes in mode bits 6:5
	localparam logic [1:0] RB_SERVICE = 2'h0;
	localparam logic [1:0] RB_MASK = 2'h1;
	localparam logic [1:0] RB_REQUEST = 2'h2;
	localparam logic [1:0] RB_ACLR = 2'h3;
	// Reset values
	localparam logic [7:0] MODE_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hff;
	localparam logic [7:0] ZERO_RST = 8'h00;
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int MIN_PULSE_NS = 100;
	localparam int MIN_PULSE_CYC = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Data port target chosen by the last preselect command
	typedef enum logic [1:0] {TGT_NONE, TGT_MASK, TGT_ACLR, TGT_VEC} port_target_t;
	// One host access on the parallel port
	typedef struct packed {
		logic sel;
		logic ctrl;
		logic rd;
		logic wr;
		logic [7:0] data;
	} host_access_t;
endpackage

// file: dv/vig_host_model.sv
// Host processor model driving the parallel port of one controller group
`timescale 1ns/1ns
module vig_host_model
	import vig_pkg::*;
(
	// Clock
	input wire logic clk_sys_i,
	// Host port towards the group
	output vig_pkg::host_access_t host_o,
	output logic ack_o
);
	// Idle bus at time zero
	initial
	begin
		host_o = '0;
		ack_o = 1'b0;
	end
	// One strobed cycle; released bus shows inverted data, never a stale value
	task automatic cycle(input logic ctrl, input logic wr, input logic [7:0] d);
		@(posedge clk_sys_i);
		host_o <= '{sel: 1'b1, ctrl: ctrl, rd: ~wr, wr: wr, data: d};
		@(posedge clk_sys_i);
		host_o <= '{sel: 1'b0, ctrl: 1'b0, rd: 1'b0, wr: 1'b0, data: ~d};
	endtask
	task automatic command(input logic [7:0] c);
		cycle(1'b1, 1'b1, c);
	endtask
	// Select the readback register first, then read the data port
	task automatic readback(input logic [1:0] rsel);
		command({OP_MODE_HI, 3'h0, rsel});
		cycle(1'b0, 1'b0, 8'h00);
	endtask
	task automatic load_aclr(input logic [7:0] v);
		command({OP_PRESEL, 5'h01});
		cycle(1'b0, 1'b1, v);
	endtask
	// Fresh preselect per vector byte, count bits zero, exactly one byte
	task automatic load_vector(input logic [2:0] slot, input logic [7:0] v);
		command({OP_VECSEL, 2'b00, slot});
		cycle(1'b0, 1'b1, v);
	endtask
	task automatic soft_reset();
		command(CMD_SOFT_RESET);
	endtask
	// Acknowledge strobe, one cycle
	task automatic ack();
		@(posedge clk_sys_i);
		ack_o <= 1'b1;
		@(posedge clk_sys_i);
		ack_o <= 1'b0;
	endtask
endmodule

// file: dv/vectored_interrupt_group_regs_tb_top.sv
// Self-checking bench for one controller group behind a host model
`timescale 1ns/1ns
module vectored_interrupt_group_regs_tb_top;
	import vig_pkg::*;
	logic clk_sys_i;
	logic reset_i;
	vig_pkg::host_access_t host;
	logic ack;
	logic [7:0] bus_data;
	logic bus_oe;
	logic [7:0] irq_pin;
	logic chain;
	logic irq;
	logic [15:0] expq[$];
	logic [15:0] e;
	logic [7:0] vec[8];
	logic [7:0] v;
	logic [7:0] m;
	int errors;
	int checked;
	// Host side and the group under test, second group so chain gating is live
	vig_host_model i_host (.clk_sys_i(clk_sys_i), .host_o(host), .ack_o(ack));
	vectored_interrupt_group_regs #(.FIRST_GROUP(1'b0), .PULSE_CYC(1)) i_dut (
		.clk_sys_i(clk_sys_i), .reset_i(reset_i), .host_i(host),
		.acknowledge_strobe_i(ack), .bus_data_o(bus_data), .bus_data_oe_o(bus_oe),
		.irq_pin_i(irq_pin), .chain_enable_in_i(chain), .group_irq_out_o(irq));
	// Clock
	initial
	begin
		clk_sys_i = 1'b0;
		forever #10 clk_sys_i = ~clk_sys_i;
	end
	task automatic compare_data(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] msk);
		checked++;
		if ((got & msk) !== (exp & msk))
		begin
			errors++;
			$display("[ERR] t=%0t data got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic compare_irq(input logic exp);
		checked++;
		if (irq !== exp)
		begin
			errors++;
			$display("[ERR] t=%0t irq got=%h exp=%h", $time, irq, exp);
		end
	endtask
	task automatic print_verdict();
		$display("errors=%0d checked=%0d", errors, checked);
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Low status bits are internal, so they are left out of the compare
	task automatic status(input logic [7:0] exp);
		expq.push_back({8'hf8, exp});
		i_host.cycle(1'b1, 1'b0, 8'h00);
	endtask
	task automatic readback(input logic [1:0] rsel, input logic [7:0] exp);
		expq.push_back({8'hff, exp});
		i_host.readback(rsel);
	endtask
	task automatic ack_expect(input int slot);
		expq.push_back({8'hff, vec[slot]});
		i_host.ack();
	endtask
	task automatic check_irq(input logic exp);
		repeat (6) @(posedge clk_sys_i);
		#1;
		compare_irq(exp);
	endtask
	task automatic req_cmd(input logic set, input logic [2:0] idx);
		i_host.command({OP_REQ, set, 1'b0, idx});
	endtask
	// Every answer on the bus is matched against the oldest note
	always @(posedge clk_sys_i)
	begin
		if (bus_oe === 1'b1)
		begin
			e = (expq.size() != 0) ? expq.pop_front() : {8'hff, ~bus_data};
			compare_data(bus_data, e[7:0], e[15:8]);
		end
	end
	// Watchdog well beyond the expected run length
	initial
	begin
		#400000;
		errors++;
		print_verdict();
	end
	// Main sequence
	initial
	begin
		errors = 0;
		checked = 0;
		reset_i <= 1'b1;
		irq_pin <= 8'h00;
		chain <= 1'b1;
		void'($urandom(32'hdae980fb));
		for (int i = 0; i < 8; i++)
			vec[i] = 8'($urandom);
		repeat (8) @(posedge clk_sys_i);
		reset_i <= 1'b0;
		// Chain synchroniser is held in reset, so let it settle before status
		repeat (4) @(posedge clk_sys_i);
		// Power-up values through status and every readback selection
		status(8'h40);
		readback(RB_SERVICE, 8'h00);
		readback(RB_MASK, 8'hff);
		readback(RB_REQUEST, 8'h00);
		readback(RB_ACLR, 8'h00);
		// Low mode bits load together; arming leaves them alone
		for (int i = 0; i < 4; i++)
		begin
			v = {3'h0, 5'($urandom) | 5'h10};
			i_host.command(v);
			status({2'b01, v[MODE_ROTATE], v[MODE_POLLED], 4'h0});
		end
		i_host.command({OP_MODE_HI, 5'h09});
		status({2'b01, v[MODE_ROTATE], v[MODE_POLLED], 4'h8});
		i_host.command({OP_MODE_HI, 5'h08});
		// Mask parallel load, then single and all set or clear
		m = 8'($urandom);
		i_host.command({OP_PRESEL, 5'h00});
		i_host.cycle(1'b0, 1'b1, m);
		readback(RB_MASK, m);
		for (int i = 0; i < 4; i++)
		begin
			i_host.command({OP_MASK, i[0], i[1], 3'(i + 2)});
			m = i[1] ? {8{i[0]}} : (i[0] ? m | (8'h1 << (i + 2)) : m & ~(8'h1 << (i + 2)));
			readback(RB_MASK, m);
		end
		v = 8'($urandom);
		i_host.load_aclr(v);
		readback(RB_ACLR, v);
		for (int i = 0; i < 8; i++)
			i_host.load_vector(3'(i), vec[i]);
		// Pin edge latches once; a level left high does not set it again
		@(posedge clk_sys_i);
		irq_pin <= 8'h81;
		repeat (8) @(posedge clk_sys_i);
		readback(RB_REQUEST, 8'h81);
		i_host.command({OP_REQ, 2'b01, 3'h0});
		repeat (8) @(posedge clk_sys_i);
		readback(RB_REQUEST, 8'h00);
		irq_pin <= 8'h00;
		req_cmd(1'b1, 3'h6);
		readback(RB_REQUEST, 8'h40);
		// Software reset restores mask and mode, keeps vectors
		i_host.soft_reset();
		status(8'h40);
		readback(RB_MASK, 8'hff);
		readback(RB_REQUEST, 8'h00);
		i_host.command({OP_MODE_HI, 5'h09});
		i_host.command({OP_MASK, 2'b01, 3'h0});
		i_host.load_aclr(8'h00);
		// Fixed priority fence rises and falls with service bits
		req_cmd(1'b1, 3'h3);
		req_cmd(1'b1, 3'h5);
		check_irq(1'b1);
		status(8'hc8);
		ack_expect(3);
		readback(RB_REQUEST, 8'h20);
		readback(RB_SERVICE, 8'h08);
		check_irq(1'b0);
		req_cmd(1'b1, 3'h1);
		check_irq(1'b1);
		ack_expect(1);
		readback(RB_SERVICE, 8'h0a);
		i_host.command({OP_SVC, 2'b00, 3'h1});
		check_irq(1'b0);
		i_host.command({OP_SVC, 2'b00, 3'h3});
		check_irq(1'b1);
		// Mask, polled mode, arming and chain gate the output
		i_host.command({OP_MASK, 2'b10, 3'h5});
		check_irq(1'b0);
		i_host.command({OP_MASK, 2'b00, 3'h5});
		check_irq(1'b1);
		i_host.command({3'h0, 5'h04});
		check_irq(1'b0);
		status(8'h58);
		i_host.command({3'h0, 5'h02});
		check_irq(1'b1);
		i_host.command({OP_MODE_HI, 5'h08});
		check_irq(1'b0);
		i_host.command({OP_MODE_HI, 5'h09});
		check_irq(1'b1);
		@(posedge clk_sys_i);
		chain <= 1'b0;
		check_irq(1'b0);
		status(8'h08);
		chain <= 1'b1;
		check_irq(1'b1);
		ack_expect(0);
		// Rotating priority: any service bit blocks; then auto-clear
		i_host.command({OP_SVC, 2'b01, 3'h0});
		i_host.command({3'h0, 5'h01});
		req_cmd(1'b1, 3'h2);
		req_cmd(1'b1, 3'h6);
		check_irq(1'b1);
		ack_expect(6);
		check_irq(1'b0);
		i_host.command({OP_SVC, 2'b00, 3'h6});
		check_irq(1'b1);
		ack_expect(2);
		i_host.command({OP_SVC, 2'b00, 3'h2});
		i_host.load_aclr(8'h10);
		req_cmd(1'b1, 3'h4);
		check_irq(1'b1);
		ack_expect(4);
		readback(RB_SERVICE, 8'h00);
		repeat (4) @(posedge clk_sys_i);
		compare_data(8'(expq.size()), 8'h00, 8'hff);
		print_verdict();
	end
endmodule
